// ==== hdl/hsq_regs.svh ====
`ifndef HSQ_REGS_SVH
`define HSQ_REGS_SVH

// ----------------------------------------------------------------
// Homing mode numbers
// ----------------------------------------------------------------
`define HSQ_MODE_W      5
`define HSQ_MODE_17     5'h11
`define HSQ_MODE_18     5'h12
`define HSQ_MODE_19     5'h13
`define HSQ_MODE_20     5'h14
`define HSQ_MODE_21     5'h15
`define HSQ_MODE_22     5'h16
`define HSQ_MODE_23     5'h17

// ----------------------------------------------------------------
// Drive encodings and reset values
// ----------------------------------------------------------------
`define HSQ_DIR_FWD     1'h1
`define HSQ_DIR_REV     1'h0
`define HSQ_SPD_FIRST   1'h0
`define HSQ_SPD_SECOND  1'h1
`define HSQ_EDGE_RISE   1'h1
`define HSQ_EDGE_FALL   1'h0
`define HSQ_RST_BIT     1'h0
`define HSQ_POS_W       32

`endif

// ==== hdl/hsq_pkg.sv ====
package hsq_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {HSQ_SIG_ORG, HSQ_SIG_FWD, HSQ_SIG_REV} hsq_sig_e;

	typedef enum logic [1:0] {HSQ_IDLE, HSQ_RUN, HSQ_DONE, HSQ_FAULT} hsq_state_e;

	typedef struct packed {
		logic     dir;
		logic     spd;
		hsq_sig_e sig;
		logic     rise;
	} hsq_seg_s;

	typedef struct packed {
		logic [1:0]         nseg;
		logic               esc;
		hsq_seg_s [2:0]     seg;
	} hsq_plan_s;

	typedef struct packed {
		logic org;
		logic fwd;
		logic rev;
		logic step;
	} hsq_sw_s;

endpackage

// ==== hdl/hsq_sync.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module hsq_sync #(
	parameter int W = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// ==== hdl/hsq_homing_sequencer.sv ====
`timescale 1ns/1ps
`include "hsq_regs.svh"

module hsq_homing_sequencer
	import hsq_pkg::*;
#(
	parameter int POS_W = `HSQ_POS_W
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    axis_home_command,
	input  wire logic                    home_abort,
	input  wire logic [`HSQ_MODE_W-1:0]  axis_mode,
	input  wire logic                    origin_sw,
	input  wire logic                    fwd_limit_sw,
	input  wire logic                    rev_limit_sw,
	input  wire logic                    axis_step,
	output logic                         drive_en_r,
	output logic                         drive_dir_r,
	output logic                         drive_spd_r,
	output logic                         busy_r,
	output logic                         home_done_r,
	output logic                         pos_zero_r,
	output logic                         mode_err_r,
	output logic signed [POS_W-1:0]      position_r
);

	// ----------------------------------------------------------------
	// Pin synchronisation and edge history
	// ----------------------------------------------------------------
	hsq_sw_s    sw_s;
	hsq_sw_s    sw_q_r;
	hsq_state_e state_r;
	hsq_state_e state_nxt;
	hsq_plan_s  plan_r;
	hsq_plan_s  plan_nxt;
	logic [1:0] idx_r;
	logic [1:0] idx_nxt;
	hsq_seg_s   cur_seg;
	logic       seg_hit;
	logic       esc_hit;
	logic       cmd_take;
	logic       step_rise;

	hsq_sync #(
		.W (4)
	) u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       ({origin_sw, fwd_limit_sw, rev_limit_sw, axis_step}),
		.q       (sw_s)
	);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			sw_q_r <= '0;
		else
			sw_q_r <= sw_s;
	end

	// ----------------------------------------------------------------
	// Plan building
	// ----------------------------------------------------------------
	function automatic hsq_seg_s seg_f(input logic dir, input logic spd,
		input hsq_sig_e sig, input logic rise);
		hsq_seg_s s;
		s.dir  = dir;
		s.spd  = spd;
		s.sig  = sig;
		s.rise = rise;
		return s;
	endfunction

	function automatic logic sig_val(input hsq_sw_s sw, input hsq_sig_e sig);
		logic v;
		case (sig)
			HSQ_SIG_ORG: v = sw.org;
			HSQ_SIG_FWD: v = sw.fwd;
			HSQ_SIG_REV: v = sw.rev;
			default:     v = 1'h0;
		endcase
		return v;
	endfunction

	function automatic logic mode_ok(input logic [`HSQ_MODE_W-1:0] m);
		return (m >= `HSQ_MODE_17) && (m <= `HSQ_MODE_23);
	endfunction

	// Two-segment plan: approach segment, then the homing segment
	function automatic hsq_plan_s two_f(input hsq_seg_s a, input hsq_seg_s b);
		hsq_plan_s p;
		p        = '0;
		p.nseg   = 2'h2;
		p.seg[0] = a;
		p.seg[1] = b;
		return p;
	endfunction

	function automatic hsq_plan_s one_f(input hsq_seg_s a);
		hsq_plan_s p;
		p        = '0;
		p.nseg   = 2'h1;
		p.seg[0] = a;
		return p;
	endfunction

	function automatic hsq_plan_s plan_f(input logic [`HSQ_MODE_W-1:0] m, input hsq_sw_s sw);
		hsq_plan_s p;
		p = '0;
		case (m)
			`HSQ_MODE_17:
				if (!sw.rev)
					p = two_f(seg_f(`HSQ_DIR_REV, `HSQ_SPD_FIRST, HSQ_SIG_REV, `HSQ_EDGE_RISE),
						seg_f(`HSQ_DIR_FWD, `HSQ_SPD_SECOND, HSQ_SIG_REV, `HSQ_EDGE_FALL));
				else
					p = one_f(seg_f(`HSQ_DIR_FWD, `HSQ_SPD_SECOND, HSQ_SIG_REV, `HSQ_EDGE_FALL));
			`HSQ_MODE_18:
				if (!sw.fwd)
					p = two_f(seg_f(`HSQ_DIR_FWD, `HSQ_SPD_FIRST, HSQ_SIG_FWD, `HSQ_EDGE_RISE),
						seg_f(`HSQ_DIR_REV, `HSQ_SPD_SECOND, HSQ_SIG_FWD, `HSQ_EDGE_FALL));
				else
					p = one_f(seg_f(`HSQ_DIR_REV, `HSQ_SPD_SECOND, HSQ_SIG_FWD, `HSQ_EDGE_FALL));
			`HSQ_MODE_19, `HSQ_MODE_23:
			begin
				if (!sw.org)
				begin
					p = two_f(seg_f(`HSQ_DIR_FWD, `HSQ_SPD_FIRST, HSQ_SIG_ORG, `HSQ_EDGE_RISE),
						seg_f(`HSQ_DIR_REV, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_FALL));
					// Only mode 23 watches the forward limit on the fast search
					p.esc = (m == `HSQ_MODE_23);
				end
				else
					p = one_f(seg_f(`HSQ_DIR_REV, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_FALL));
			end
			`HSQ_MODE_20:
				if (!sw.org)
					p = one_f(seg_f(`HSQ_DIR_FWD, `HSQ_SPD_FIRST, HSQ_SIG_ORG, `HSQ_EDGE_RISE));
				else
					p = two_f(seg_f(`HSQ_DIR_REV, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_FALL),
						seg_f(`HSQ_DIR_FWD, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_RISE));
			`HSQ_MODE_21:
				if (!sw.org)
					p = two_f(seg_f(`HSQ_DIR_REV, `HSQ_SPD_FIRST, HSQ_SIG_ORG, `HSQ_EDGE_RISE),
						seg_f(`HSQ_DIR_FWD, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_FALL));
				else
					p = one_f(seg_f(`HSQ_DIR_FWD, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_FALL));
			`HSQ_MODE_22:
				if (sw.org)
					p = two_f(seg_f(`HSQ_DIR_FWD, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_FALL),
						seg_f(`HSQ_DIR_REV, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_RISE));
				else
					p = one_f(seg_f(`HSQ_DIR_REV, `HSQ_SPD_FIRST, HSQ_SIG_ORG, `HSQ_EDGE_RISE));
			default:
				p = '0;
		endcase
		return p;
	endfunction

	// Escape path once the forward limit is struck: back up fast, then slow
	function automatic hsq_plan_s esc_plan_f();
		return two_f(seg_f(`HSQ_DIR_REV, `HSQ_SPD_FIRST, HSQ_SIG_ORG, `HSQ_EDGE_RISE),
			seg_f(`HSQ_DIR_REV, `HSQ_SPD_SECOND, HSQ_SIG_ORG, `HSQ_EDGE_FALL));
	endfunction

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	assign cmd_take  = axis_home_command && (state_r != HSQ_RUN);
	assign cur_seg   = plan_r.seg[idx_r];
	assign seg_hit   = cur_seg.rise ?
		(sig_val(sw_s, cur_seg.sig) && !sig_val(sw_q_r, cur_seg.sig)) :
		(!sig_val(sw_s, cur_seg.sig) && sig_val(sw_q_r, cur_seg.sig));
	assign esc_hit   = plan_r.esc && (idx_r == 2'h0) && sw_s.fwd && !sw_q_r.fwd;
	assign step_rise = sw_s.step && !sw_q_r.step;

	// Commands during a run are ignored; abort is the only way out early
	always_comb
	begin
		state_nxt = state_r;
		idx_nxt   = idx_r;
		plan_nxt  = plan_r;
		case (state_r)
			HSQ_IDLE, HSQ_DONE, HSQ_FAULT:
			begin
				if (cmd_take)
				begin
					if (mode_ok(axis_mode))
					begin
						plan_nxt  = plan_f(axis_mode, sw_s);
						idx_nxt   = 2'h0;
						state_nxt = HSQ_RUN;
					end
					else
						state_nxt = HSQ_FAULT;
				end
			end
			HSQ_RUN:
			begin
				if (home_abort)
					state_nxt = HSQ_IDLE;
				else if (esc_hit)
				begin
					plan_nxt = esc_plan_f();
					idx_nxt  = 2'h0;
				end
				else if (seg_hit)
				begin
					if (idx_r == plan_r.nseg - 2'h1)
						state_nxt = HSQ_DONE;
					else
						idx_nxt = idx_r + 2'h1;
				end
			end
			default:
				state_nxt = HSQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= HSQ_IDLE;
			idx_r   <= 2'h0;
			plan_r  <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			idx_r   <= idx_nxt;
			plan_r  <= plan_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Drive outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			drive_en_r  <= `HSQ_RST_BIT;
			drive_dir_r <= `HSQ_RST_BIT;
			drive_spd_r <= `HSQ_RST_BIT;
		end
		else
		begin
			drive_en_r  <= (state_nxt == HSQ_RUN);
			drive_dir_r <= plan_nxt.seg[idx_nxt].dir;
			drive_spd_r <= plan_nxt.seg[idx_nxt].spd;
		end
	end

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			busy_r      <= `HSQ_RST_BIT;
			home_done_r <= `HSQ_RST_BIT;
			pos_zero_r  <= `HSQ_RST_BIT;
			mode_err_r  <= `HSQ_RST_BIT;
		end
		else
		begin
			busy_r      <= (state_nxt == HSQ_RUN);
			home_done_r <= (state_nxt == HSQ_DONE);
			pos_zero_r  <= (state_r == HSQ_RUN) && (state_nxt == HSQ_DONE);
			mode_err_r  <= (state_nxt == HSQ_FAULT);
		end
	end

	// ----------------------------------------------------------------
	// Position reference
	// ----------------------------------------------------------------
	// Steps are counted only while driving; zeroing wins over a step
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			position_r <= '0;
		else if ((state_r == HSQ_RUN) && (state_nxt == HSQ_DONE))
			position_r <= '0;
		else if (step_rise && drive_en_r)
			position_r <= drive_dir_r ? position_r + POS_W'(1) : position_r - POS_W'(1);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	chk_m17_start: assert property (
		cmd_take && (axis_mode == `HSQ_MODE_17) |=> drive_en_r &&
			(drive_dir_r == $past(sw_s.rev)) && (drive_spd_r == $past(sw_s.rev)))
		else $error("mode 17 start wrong");

	chk_m18_start: assert property (
		cmd_take && (axis_mode == `HSQ_MODE_18) |=> drive_en_r &&
			(drive_dir_r == !$past(sw_s.fwd)) && (drive_spd_r == $past(sw_s.fwd)))
		else $error("mode 18 start wrong");

	chk_m19_start: assert property (
		cmd_take && ((axis_mode == `HSQ_MODE_19) || (axis_mode == `HSQ_MODE_23)) |=>
			drive_en_r && (drive_dir_r == !$past(sw_s.org)) && (drive_spd_r == $past(sw_s.org)))
		else $error("mode 19/23 start wrong");

	chk_m20_start: assert property (
		cmd_take && (axis_mode == `HSQ_MODE_20) |=> drive_en_r &&
			(drive_dir_r == !$past(sw_s.org)) && (drive_spd_r == $past(sw_s.org)))
		else $error("mode 20 start wrong");

	chk_m21_start: assert property (
		cmd_take && ((axis_mode == `HSQ_MODE_21) || (axis_mode == `HSQ_MODE_22)) |=>
			drive_en_r && (drive_dir_r == $past(sw_s.org)) && (drive_spd_r == $past(sw_s.org)))
		else $error("mode 21/22 start wrong");

	chk_escape_reverse: assert property (
		(state_r == HSQ_RUN) && esc_hit && !home_abort |=>
			drive_en_r && (drive_dir_r == `HSQ_DIR_REV) && (drive_spd_r == `HSQ_SPD_FIRST))
		else $error("limit escape did not reverse at first speed");

	chk_home_stop: assert property (
		(state_r == HSQ_RUN) && !home_abort && !esc_hit && seg_hit &&
			(idx_r == plan_r.nseg - 2'h1) |=> !drive_en_r && home_done_r && pos_zero_r &&
			(position_r == '0) ##1 !pos_zero_r)
		else $error("home edge did not stop and zero");

	chk_done_holds: assert property (
		home_done_r && !axis_home_command |=> home_done_r && !drive_en_r)
		else $error("done dropped without a command");

	chk_bad_mode: assert property (
		cmd_take && !mode_ok(axis_mode) |=> mode_err_r && !drive_en_r && !busy_r)
		else $error("invalid mode moved the axis");

	chk_busy_ignores: assert property (
		busy_r && axis_home_command && !home_abort && !seg_hit && !esc_hit |=>
			$stable(plan_r) && $stable(idx_r))
		else $error("command during run changed plan");

	cov_home_two: cover property (
		cmd_take ##1 (busy_r && idx_r == 2'h1) [*2] ##[1:1000] $rose(home_done_r));

	cov_escape: cover property (
		(state_r == HSQ_RUN) && esc_hit ##[1:1000] $rose(home_done_r));

	cov_abort: cover property (busy_r && home_abort ##1 !busy_r);

	cov_fault: cover property ($rose(mode_err_r));

endmodule

// ==== tb/hsq_axis_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Axis drive and switch model
// ----------------------------------------------------------------
module hsq_axis_model (
	input  wire logic ref_clk,
	input  wire logic drive_en_r,
	input  wire logic drive_dir_r,
	input  wire logic drive_spd_r,
	output logic      origin_sw,
	output logic      fwd_limit_sw,
	output logic      rev_limit_sw,
	output logic      axis_step
);
	localparam int ORG_LO = 100;
	localparam int ORG_HI = 119;
	localparam int FWD_AT = 200;
	localparam int FAST_P = 4;
	localparam int SLOW_P = 8;

	int pos  = 50;
	int tick = 0;

	initial axis_step = 1'b0;

	// Only called while the drive is stopped, so no race with stepping
	task automatic place(input int p);
		pos = p;
	endtask

	// Switches are levels of the axis position, not latched
	assign origin_sw    = (pos >= ORG_LO) && (pos <= ORG_HI);
	assign fwd_limit_sw = pos >= FWD_AT;
	assign rev_limit_sw = pos <= 0;

	always @(posedge ref_clk)
	begin
		axis_step <= 1'b0;
		if (drive_en_r === 1'b1)
		begin
			tick <= tick + 1;
			if (tick >= (drive_spd_r ? SLOW_P : FAST_P) - 1)
			begin
				tick      <= 0;
				axis_step <= 1'b1;
				pos       <= drive_dir_r ? pos + 1 : pos - 1;
			end
		end
		else
			tick <= 0;
	end
endmodule

// ==== tb/hsq_homing_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`include "hsq_regs.svh"

module hsq_homing_sequencer_tb_top;
	localparam logic [1:0] F1 = 2'h2;
	localparam logic [1:0] F2 = 2'h3;
	localparam logic [1:0] R1 = 2'h0;
	localparam logic [1:0] R2 = 2'h1;

	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic              axis_home_command = 1'b0;
	logic              home_abort = 1'b0;
	logic [4:0]        axis_mode = `HSQ_MODE_17;
	logic              origin_sw, fwd_limit_sw, rev_limit_sw, axis_step;
	logic              drive_en_r, drive_dir_r, drive_spd_r, busy_r;
	logic              home_done_r, pos_zero_r, mode_err_r;
	logic signed [15:0] position_r;
	int                fail_count = 0;
	int                checked = 0;

	// Start places: low-side, on origin, high-side, on a limit
	logic [4:0] t_mode [15] = '{5'h11, 5'h11, 5'h12, 5'h12, 5'h13, 5'h13, 5'h14, 5'h14,
		5'h15, 5'h15, 5'h16, 5'h16, 5'h17, 5'h17, 5'h17};
	int t_place [15] = '{50, -5, 150, 205, 50, 110, 50, 110, 150, 110, 110, 150, 50, 110, 150};
	int t_spread [15] = '{30, 0, 30, 0, 30, 5, 30, 5, 30, 5, 5, 30, 30, 5, 29};

	hsq_homing_sequencer #(.POS_W(16)) dut (.ref_clk(ref_clk), .rst(rst),
		.axis_home_command(axis_home_command), .home_abort(home_abort),
		.axis_mode(axis_mode), .origin_sw(origin_sw), .fwd_limit_sw(fwd_limit_sw),
		.rev_limit_sw(rev_limit_sw), .axis_step(axis_step), .drive_en_r(drive_en_r),
		.drive_dir_r(drive_dir_r), .drive_spd_r(drive_spd_r), .busy_r(busy_r),
		.home_done_r(home_done_r), .pos_zero_r(pos_zero_r), .mode_err_r(mode_err_r),
		.position_r(position_r));

	hsq_axis_model axis (.ref_clk(ref_clk), .drive_en_r(drive_en_r),
		.drive_dir_r(drive_dir_r), .drive_spd_r(drive_spd_r), .origin_sw(origin_sw),
		.fwd_limit_sw(fwd_limit_sw), .rev_limit_sw(rev_limit_sw), .axis_step(axis_step));

	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Expected segment list: count, then dir/speed per segment
	// ----------------------------------------------------------------
	function automatic logic [7:0] exp_plan(input logic [4:0] m, input logic o, f, r, e);
		case (m)
			`HSQ_MODE_17: return r ? {2'h1, F2, 4'h0} : {2'h2, R1, F2, 2'h0};
			`HSQ_MODE_18: return f ? {2'h1, R2, 4'h0} : {2'h2, F1, R2, 2'h0};
			`HSQ_MODE_19: return o ? {2'h1, R2, 4'h0} : {2'h2, F1, R2, 2'h0};
			`HSQ_MODE_20: return o ? {2'h2, R2, F2, 2'h0} : {2'h1, F1, 4'h0};
			`HSQ_MODE_21: return o ? {2'h1, F2, 4'h0} : {2'h2, R1, F2, 2'h0};
			`HSQ_MODE_22: return o ? {2'h2, F2, R2, 2'h0} : {2'h1, R1, 4'h0};
			default: return o ? {2'h1, R2, 4'h0} : e ? {2'h3, F1, R1, R2} : {2'h2, F1, R2, 2'h0};
		endcase
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic command(input logic [4:0] m);
		// Inputs change only on a rising edge
		@(posedge ref_clk);
		axis_mode         <= m;
		axis_home_command <= 1'b1;
		@(posedge ref_clk);
		axis_home_command <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic run_case(input logic [4:0] m, input int p, input bit poke);
		logic [7:0] exp;
		logic [1:0] s [3];
		logic [1:0] code, last;
		int         cnt, n;
		axis.place(p);
		repeat (4) @(posedge ref_clk);
		exp = exp_plan(m, origin_sw, fwd_limit_sw, rev_limit_sw, m == `HSQ_MODE_23 && p > 119);
		s = '{2'b00, 2'b00, 2'b00};
		cnt = 0;
		last = 2'b00;
		command(m);
		check("busy", busy_r, 1'h1);
		check("first seg", {drive_en_r, drive_dir_r, drive_spd_r}, {1'h1, exp[5:4]});
		check("done cleared", {home_done_r, mode_err_r}, 2'h0);
		for (n = 0; n < 6000 && home_done_r !== 1'b1; n++)
		begin
			code = {drive_dir_r, drive_spd_r};
			if (drive_en_r === 1'b1 && (cnt == 0 || code !== last))
			begin
				if (cnt < 3)
					s[cnt] = code;
				cnt++;
				last = code;
			end
			@(posedge ref_clk);
			// A command during a run must be ignored
			axis_home_command <= poke && n == 30;
			axis_mode         <= (poke && n == 30) ? `HSQ_MODE_20 : m;
			#1;
		end
		check("segments", cnt, exp[7:6]);
		check("plan", {s[0], s[1], s[2]}, exp[5:0]);
		check("stopped", {drive_en_r, busy_r, home_done_r}, 3'h1);
		check("zero pulse", pos_zero_r, 1'h1);
		check("position", position_r, 32'h0);
		@(posedge ref_clk);
		#1;
		check("zero pulse end", pos_zero_r, 1'h0);
		repeat (4) @(posedge ref_clk);
		#1;
		check("done stands", {home_done_r, position_r}, {1'h1, 16'h0});
		$display("test mode %0d start %0d done", m, p);
	endtask

	task automatic finish_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		int i;
		void'($urandom(32'hf460));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		for (i = 0; i < 15; i++)
			run_case(t_mode[i], t_place[i] + $urandom_range(t_spread[i], 0), i == 14);
		repeat (6)
		begin
			i = $urandom_range(14, 0);
			run_case(t_mode[i], t_place[i] + $urandom_range(t_spread[i], 0), 1'b0);
		end
		// Re-home, then a mode outside the offered set
		run_case(`HSQ_MODE_19, 60, 1'b0);
		command(5'h18 + 5'($urandom_range(7, 0)));
		check("bad mode", {mode_err_r, drive_en_r, busy_r}, 3'h4);
		$display("test invalid mode done");
		// Abort mid-run must not declare home; the restart command clears the fault
		axis.place(60);
		repeat (4) @(posedge ref_clk);
		command(`HSQ_MODE_19);
		check("mode err cleared", mode_err_r, 1'h0);
		repeat (10) @(posedge ref_clk);
		home_abort <= 1'b1;
		@(posedge ref_clk);
		home_abort <= 1'b0;
		@(posedge ref_clk);
		#1;
		check("abort", {drive_en_r, busy_r, home_done_r, pos_zero_r}, 4'h0);
		// Two fast steps pass the synchroniser before the drive stops counting
		check("abort position", position_r, 32'h2);
		$display("test abort done");
		finish_test();
	end

	initial
	begin
		repeat (90000) @(posedge ref_clk);
		fail_count++;
		finish_test();
	end
endmodule
